// >>> hdl/tlc_pkg.sv
// tlc_pkg: constants and carriers for the sample checker
// assumes one 100 MHz clock and byte-wide registers
package tlc_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] TLC_A_SEL = 12'h32c;
  localparam logic [11:0] TLC_A_REFL = 12'h32d;
  localparam logic [11:0] TLC_A_REFH = 12'h32e;
  localparam logic [11:0] TLC_A_RES = 12'h32f;
  localparam logic [11:0] TLC_A_INV = 12'h334;
  localparam logic [11:0] TLC_A_ISTS = 12'h335;
  localparam logic [11:0] TLC_A_IMSK = 12'h336;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TLC_F_EN = 0;
  localparam int TLC_F_CLR = 1;
  localparam int TLC_F_CH = 2;
  localparam int TLC_F_IDX = 4;
  localparam int TLC_F_IQ = 6;
  localparam int TLC_F_FAIL = 0;
  localparam int TLC_E_FAIL = 0;
  localparam int TLC_E_DONE = 1;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int TLC_LANES = 8;
  localparam int TLC_LW = 8;
  localparam logic [7:0] TLC_RST8 = 8'h00;
  localparam logic [1:0] TLC_RST2 = 2'h0;

  // one demapped sample from the receiver
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic iq;
    logic [3:0] idx;
    logic [15:0] data;
  } tlc_smp_t;

  // one register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } tlc_req_t;

endpackage

// >>> hdl/tlc_checker.sv
// tlc_checker: transport sample check and lane inversion
// assumes inputs synchronous to CLK, one access per strobe
`timescale 1ns/100ps
`default_nettype none

// Contract
// - sample index field picks sample 0..15
// - channel field picks converter channel 0..2
// - writing one to clear bit clears result
// - compare only while enable bit is one
// - reference low byte at 0x32D
// - reference high byte at 0x32E
// - compare reference with selected received sample
// - bit six picks I or Q
// - result bit reads one on mismatch
// - per lane bit inverts deserialized lane data
module tlc_checker
  import tlc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire tlc_req_t BUS_REQ,
  output logic [7:0] BUS_RDATA,
  input wire tlc_smp_t RX_SMP,
  input wire logic [63:0] LANE_DIN,
  output logic [63:0] LANE_DOUT,
  output logic FAIL,
  output logic IRQ
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // enable bit
  logic en_q;
  // channel select
  logic [1:0] ch_q;
  // sample index
  logic [3:0] idx_q;
  // I/Q select
  logic iq_q;
  // reference value
  logic [15:0] ref_q;
  // lane invert mask
  logic [7:0] inv_q;
  // sticky fail result
  logic fail_q;
  logic fail_d;
  // event status and mask
  logic [1:0] sts_q;
  logic [1:0] sts_d;
  logic [1:0] msk_q;
  // read data and irq flops
  logic [7:0] rdata_q;
  logic irq_q;
  logic [63:0] dout_q;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // a write only counts while CE is high
  wire logic wr_w = CE & BUS_REQ.wr;
  wire logic rd_w = CE & BUS_REQ.rd;
  wire logic hit_sel = BUS_REQ.addr == TLC_A_SEL;
  wire logic hit_refl = BUS_REQ.addr == TLC_A_REFL;
  wire logic hit_refh = BUS_REQ.addr == TLC_A_REFH;
  wire logic hit_res = BUS_REQ.addr == TLC_A_RES;
  wire logic hit_inv = BUS_REQ.addr == TLC_A_INV;
  wire logic hit_ists = BUS_REQ.addr == TLC_A_ISTS;
  wire logic hit_imsk = BUS_REQ.addr == TLC_A_IMSK;

  // decodes are full twelve-bit compares; aliasing a partial decode
  // would let writes to neighbouring link registers land here
  // clear strobe, one cycle, bit never stored
  // storing it would leave a clear pending and eat the next fail
  wire logic clr_w = wr_w & hit_sel & BUS_REQ.wdata[TLC_F_CLR];

  // ----------------------------------------
  // compare path
  // ----------------------------------------
  // the source tags each sample, so selection is a plain tag compare
  // rather than a position counter that could slip against the frame
  // index match
  wire logic m_idx = RX_SMP.idx == idx_q;
  wire logic m_ch = RX_SMP.chan == ch_q;
  wire logic m_iq = RX_SMP.iq == iq_q;
  wire logic fire_w = CE & en_q & RX_SMP.valid & m_idx & m_ch & m_iq;
  wire logic mism_w = fire_w & (RX_SMP.data != ref_q);

  // hold until clear; set beats clear
  assign fail_d = mism_w | (fail_q & ~clr_w);

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  // new fail fires only on the 0 to 1 edge of the result, so a
  // stuck mismatch raises one interrupt and not one per frame
  // events: new fail, any compare done
  wire logic [1:0] ev_w = {fire_w, mism_w & ~fail_q};
  // write-one clears, an event in the same cycle wins
  wire logic [1:0] w1c_w = (wr_w & hit_ists) ? BUS_REQ.wdata[1:0] : TLC_RST2;
  assign sts_d = ev_w | (sts_q & ~w1c_w);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // the mux is registered below; reads never stall the bus
  // selection reads back with clear bit at zero
  wire logic [7:0] rd_sel = {idx_q, ch_q, 1'b0, en_q};
  wire logic [7:0] rd_res = {1'b0, iq_q, 5'h00, fail_q};
  // unmapped addresses read zero
  wire logic [7:0] rd_mux =
    hit_sel ? rd_sel :
    hit_refl ? ref_q[7:0] :
    hit_refh ? ref_q[15:8] :
    hit_res ? rd_res :
    hit_inv ? inv_q :
    hit_ists ? {6'h00, sts_q} :
    hit_imsk ? {6'h00, msk_q} : TLC_RST8;

  // ----------------------------------------
  // lane inversion
  // ----------------------------------------
  // inversion sits on the whole lane byte; a lane swapped in polarity
  // on the board is mended here without touching the far end
  // each mask bit spread over its lane
  logic [63:0] inv_w;
  genvar gl;
  generate
    for (gl = 0; gl < TLC_LANES; gl++) begin : g_lane
      assign inv_w[gl*TLC_LW +: TLC_LW] = {TLC_LW{inv_q[gl]}};
    end
  endgenerate

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // selection fields from 0x32c
  // changing the selection does not clear the result; software
  // clears it in the same write if it wants a fresh run
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_q <= 1'b0;
      ch_q <= TLC_RST2;
      idx_q <= 4'h0;
    end else if (wr_w && hit_sel) begin
      en_q <= BUS_REQ.wdata[TLC_F_EN];
      ch_q <= BUS_REQ.wdata[TLC_F_CH +: 2];
      idx_q <= BUS_REQ.wdata[TLC_F_IDX +: 4];
    end
  end

  // reference bytes
  // bytes are taken independently; a check running while only one
  // byte is updated can see a torn reference, so disable first
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ref_q <= 16'h0000;
    end else begin
      if (wr_w && hit_refl) begin
        ref_q[7:0] <= BUS_REQ.wdata;
      end
      if (wr_w && hit_refh) begin
        ref_q[15:8] <= BUS_REQ.wdata;
      end
    end
  end

  // component select, invert mask, irq mask
  // reserved bits of the result register are not stored at all
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      iq_q <= 1'b0;
      inv_q <= TLC_RST8;
      msk_q <= TLC_RST2;
    end else begin
      if (wr_w && hit_res) begin
        iq_q <= BUS_REQ.wdata[TLC_F_IQ];
      end
      if (wr_w && hit_inv) begin
        inv_q <= BUS_REQ.wdata;
      end
      if (wr_w && hit_imsk) begin
        msk_q <= BUS_REQ.wdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // result, status, outputs
  // ----------------------------------------
  // everything freezes while CE is low
  // the lane path shares this enable, so a frozen block holds its
  // last lane word rather than passing raw data through
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fail_q <= 1'b0;
      sts_q <= TLC_RST2;
      irq_q <= 1'b0;
      rdata_q <= TLC_RST8;
      dout_q <= 64'h0;
    end else if (CE) begin
      fail_q <= fail_d;
      sts_q <= sts_d;
      // irq follows masked status one cycle later
      irq_q <= |(sts_q & msk_q);
      // read data only valid after a read
      rdata_q <= rd_w ? rd_mux : TLC_RST8;
      dout_q <= LANE_DIN ^ inv_w;
    end
  end

  assign BUS_RDATA = rdata_q;
  assign FAIL = fail_q;
  assign IRQ = irq_q;
  assign LANE_DOUT = dout_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sel_index_a: assert property (
    $rose(fail_q) |-> $past(RX_SMP.idx) == $past(idx_q))
    else $error("fail rose on wrong sample index");

  sel_chan_a: assert property (
    $rose(fail_q) |-> $past(RX_SMP.chan) == $past(ch_q))
    else $error("fail rose on wrong channel");

  clear_fail_a: assert property (
    clr_w && !mism_w |=> !fail_q)
    else $error("clear did not drop fail");

  en_gate_a: assert property (
    CE && !en_q && !fail_q |=> !fail_q)
    else $error("fail set while check disabled");

  ref_low_a: assert property (
    wr_w && hit_refl |=> ref_q[7:0] == $past(BUS_REQ.wdata))
    else $error("low reference byte not stored");

  ref_high_a: assert property (
    wr_w && hit_refh |=> ref_q[15:8] == $past(BUS_REQ.wdata))
    else $error("high reference byte not stored");

  mism_set_a: assert property (
    mism_w |=> fail_q ##1 (fail_q || $past(clr_w)))
    else $error("mismatch did not set fail");

  match_keep_a: assert property (
    fire_w && RX_SMP.data == ref_q && !fail_q |=> !fail_q)
    else $error("match wrongly set fail");

  sel_iq_a: assert property (
    $rose(fail_q) |-> $past(RX_SMP.iq) == $past(iq_q))
    else $error("fail rose on wrong component");

  rd_fail_a: assert property (
    rd_w && hit_res |=> BUS_RDATA[0] == $past(fail_q))
    else $error("result bit read back wrong");

  lane_inv_a: assert property (
    CE |=> LANE_DOUT == ($past(LANE_DIN) ^ $past(inv_w)))
    else $error("lane data not inverted per mask");

  fail_hold_a: assert property (
    fail_q && !clr_w |=> fail_q)
    else $error("fail dropped without clear");

  irq_out_a: assert property (
    CE |=> IRQ == $past(|(sts_q & msk_q)))
    else $error("irq does not follow masked status");

  cov_fail_c: cover property (mism_w ##1 fail_q);
  cov_clear_c: cover property (fail_q ##1 clr_w ##1 !fail_q);
  cov_pass_c: cover property (fire_w && !mism_w);
  cov_irq_c: cover property ($rose(IRQ));
  cov_chan2_c: cover property (fire_w && RX_SMP.chan == 2'h2);

  // ----------------------------------------
  // bus and status assertions
  // ----------------------------------------
  // read data must not linger past its one cycle
  rd_idle_a: assert property (
    CE && !rd_w |=> BUS_RDATA == TLC_RST8)
    else $error("read data stands past its cycle");

  // the clear bit is a pulse and never reads back
  clr_read_a: assert property (
    rd_w && hit_sel |=> BUS_RDATA[TLC_F_CLR] == 1'b0)
    else $error("clear bit read back as one");

  // status bits stay until written one
  sts_hold_a: assert property (
    CE && !(wr_w && hit_ists) |=> (sts_q & $past(sts_q)) == $past(sts_q))
    else $error("status bit dropped without write");

  // a new fail always raises its status bit
  sts_fail_a: assert property (
    mism_w && !fail_q |=> sts_q[TLC_E_FAIL])
    else $error("new fail did not set status");

  // every selected compare marks compare done
  sts_done_a: assert property (
    fire_w |=> sts_q[TLC_E_DONE])
    else $error("compare did not set done status");

  // the component bit reads back as written
  iq_store_a: assert property (
    wr_w && hit_res |=> iq_q == $past(BUS_REQ.wdata[TLC_F_IQ]))
    else $error("component bit not stored");

  // the mask is taken whole in one write
  inv_store_a: assert property (
    wr_w && hit_inv |=> inv_q == $past(BUS_REQ.wdata))
    else $error("invert mask not stored");

endmodule

`default_nettype wire

// >>> dv/tlc_src.sv
// tlc_src: sample source in place of the link transmitter
// assumes the bench sets tag, reference and fault just after clock edges
`timescale 1ns/100ps
`default_nettype none
module tlc_src
  import tlc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] ref_val,
  input wire logic [6:0] want,
  input wire logic bad,
  output tlc_smp_t smp
);
  logic [7:0] cnt_q; // walks every chan/iq/idx tag
  logic hit; // the wanted tag, valid cycle
  // ------------------------------
  // tag walk, valid on odd counts
  // ------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  assign hit = cnt_q[0] && (cnt_q[7:1] == want);
  // every other sample differs, so a wrong select or a stale valid shows up
  assign smp = '{valid: cnt_q[0], chan: cnt_q[7:6], iq: cnt_q[5], idx: cnt_q[4:1],
    data: (hit && !bad) ? ref_val : (ref_val ^ {8'h80, cnt_q})};
endmodule
`default_nettype wire

// >>> dv/tb.sv
// tb: self-checking bench for the sample checker
// assumes tlc_pkg, tlc_checker and tlc_src are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tlc_pkg::*;
  logic clk, rst, bad, irq, fail;
  tlc_req_t req;
  tlc_smp_t smp;
  logic [7:0] rdat, d, m, sel;
  logic [63:0] din, dout;
  logic [15:0] refv;
  logic [6:0] want;
  logic [31:0] lfsr = 32'h7063, r;
  int err_count = 0, checks_done = 0;
  logic [11:0] ra [0:4] = '{12'h32c, 12'h32d, 12'h32e, 12'h32f, 12'h334};
  logic [7:0] rm [0:4] = '{8'hfd, 8'hff, 8'hff, 8'h40, 8'hff};
  tlc_src u_src (.clk(clk), .rst(rst), .ref_val(refv), .want(want), .bad(bad), .smp(smp));
  tlc_checker u_dut (.CLK(clk), .RST(rst), .CE(1'b1), .BUS_REQ(req), .BUS_RDATA(rdat),
    .RX_SMP(smp), .LANE_DIN(din), .LANE_DOUT(dout), .FAIL(fail), .IRQ(irq));
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // expected lane output: whole byte flipped per mask bit
  function automatic logic [63:0] inv(input logic [63:0] v, input logic [7:0] k);
    for (int i = 0; i < 8; i++) v[8*i+:8] ^= {8{k[i]}};
    return v;
  endfunction
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk) req <= '{1'b1, 1'b0, a, v};
    @(posedge clk) req <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 v = rdat;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ------------------------------
  // clock, reset, watchdog
  // ------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000 err_count++;
    stop_test();
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    rst = 1; req = '0; din = '0; refv = '0; want = '0; bad = 0;
    repeat (12) @(posedge clk);
    rst <= 0;
    foreach (ra[i]) begin
      rd(ra[i], d); chk(d, 0);
    end
    rd(12'h300, d); chk(d, 0);
    foreach (ra[i]) begin
      r = rnd(); wr(ra[i], r[7:0] & rm[i]); rd(ra[i], d); chk(d, r[7:0] & rm[i]);
    end
    $display("register test done");
    for (int i = 0; i < 10; i++) begin
      m = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd();
      wr(TLC_A_INV, m);
      @(posedge clk) din <= {rnd(), rnd()};
      @(posedge clk);
      #1 chk(dout, inv(din, m));
    end
    $display("lane test done");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      want = {(r[1:0] == 2'h3) ? 2'h2 : r[1:0], r[6],
        (i == 0) ? 4'h0 : (i == 1) ? 4'hf : r[5:2]};
      refv = r[31:16]; bad <= 0;
      sel = {want[3:0], want[6:5], 2'h3};
      wr(TLC_A_REFL, refv[7:0]); wr(TLC_A_REFH, refv[15:8]);
      wr(TLC_A_RES, {1'b0, want[4], 6'h00}); wr(TLC_A_IMSK, 8'h01);
      wr(TLC_A_SEL, sel); wr(TLC_A_ISTS, 8'h03);
      idle(300); chk(fail, 0);
      bad <= 1; idle(300); chk(fail, 1);
      rd(TLC_A_RES, d); chk(d, {1'b0, want[4], 6'h01});
      chk(irq, 1);
      rd(TLC_A_ISTS, d); chk(d, 8'h03);
      wr(TLC_A_ISTS, 8'h03); idle(3); chk(irq, 0);
      bad <= 0; idle(300); chk(fail, 1);
      wr(TLC_A_SEL, {sel[7:1], 1'b0}); bad <= 1; idle(300); chk(fail, 0);
    end
    $display("sample check test done");
    stop_test();
  end
endmodule
`default_nettype wire
